// ---- logic/sfb_pkg.sv ----
// package for the status frame builder: frame constants, codes and carriers
package sfb_pkg;
  localparam logic [7:0] SFB_START = 8'h7E;
  localparam logic [7:0] SFB_TYPE_MODEM = 8'h8A;
  localparam logic [7:0] SFB_TYPE_TXST = 8'h8B;
  localparam logic [7:0] SFB_REQ_TX = 8'h10;
  localparam logic [7:0] SFB_REQ_EXPL = 8'h11;
  localparam logic [7:0] SFB_CKS_BASE = 8'hFF;
  localparam logic [15:0] SFB_RESERVED = 16'hFFFE;
  localparam logic [15:0] SFB_LEN_MODEM = 16'h0002;
  localparam logic [15:0] SFB_LEN_TXST = 16'h0007;
  localparam logic [7:0] SFB_FID_NONE = 8'h00;
  // modem status codes
  localparam logic [7:0] SFB_MS_HW_RESET = 8'h00;
  localparam logic [7:0] SFB_MS_WDOG = 8'h01;
  localparam logic [7:0] SFB_MS_JOINED = 8'h02;
  localparam logic [7:0] SFB_MS_LEFT = 8'h03;
  localparam logic [7:0] SFB_MS_WOKE = 8'h0B;
  localparam logic [7:0] SFB_MS_SLEEP = 8'h0C;
  localparam logic [7:0] SFB_MS_VOLT = 8'h0D;
  localparam logic [7:0] SFB_MS_STACK_MIN = 8'h80;
  // delivery status codes
  localparam logic [7:0] SFB_DS_OK = 8'h00;
  localparam logic [7:0] SFB_DS_MAC_ACK = 8'h01;
  localparam logic [7:0] SFB_DS_CCA = 8'h02;
  localparam logic [7:0] SFB_DS_NET_ACK = 8'h21;
  localparam logic [7:0] SFB_DS_NO_ROUTE = 8'h25;
  localparam logic [7:0] SFB_DS_INTERNAL = 8'h31;
  localparam logic [7:0] SFB_DS_NO_BUF = 8'h32;
  localparam logic [7:0] SFB_DS_TOO_BIG = 8'h74;
  // discovery status codes
  localparam logic [7:0] SFB_DISC_NONE = 8'h00;
  localparam logic [7:0] SFB_DISC_ROUTE = 8'h02;
  // byte offsets within a frame
  localparam logic [3:0] SFB_OFS_LEN_HI = 4'h1;
  localparam logic [3:0] SFB_OFS_LEN_LO = 4'h2;
  localparam logic [3:0] SFB_OFS_TYPE = 4'h3;
  localparam logic [3:0] SFB_OFS_B4 = 4'h4;
  localparam logic [3:0] SFB_OFS_RSV_HI = 4'h5;
  localparam logic [3:0] SFB_OFS_RSV_LO = 4'h6;
  localparam logic [3:0] SFB_OFS_RETRY = 4'h7;
  localparam logic [3:0] SFB_OFS_DELIV = 4'h8;
  localparam logic [3:0] SFB_OFS_DISC = 4'h9;
  localparam logic [3:0] SFB_LAST_MODEM = 4'h5;
  localparam logic [3:0] SFB_LAST_TXST = 4'hA;
  localparam int SFB_FIFO_DEPTH = 16;

  // completed transmit request as reported by the network side
  typedef struct packed {
    logic [7:0] req_type;
    logic [7:0] frame_id;
    logic [7:0] retries;
    logic [7:0] delivery;
    logic [7:0] discovery;
    logic broadcast;
  } sfb_txdone_t;

  // serial byte leaving the block
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } sfb_byte_t;

  typedef enum logic [1:0] {
    SFB_IDLE = 2'b00,
    SFB_SEND = 2'b01
  } sfb_state_t;
endpackage

// ---- logic/sfb_fifo.sv ----
// status frame builder output fifo
`timescale 1ns/100ps
module sfb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  // refuse depths that the pointer wrap cannot serve
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("sfb_fifo: depth must be a power of two of at least 2");
    end
  end
  logic [WIDTH-1:0] mem [DEPTH];  // storage words
  logic [AW:0] wr_ptr;  // write pointer with wrap bit
  logic [AW:0] rd_ptr;  // read pointer with wrap bit
  wire logic do_wr = in_valid && in_ready;
  wire logic do_rd = out_valid && out_ready;
  wire logic [AW:0] count = wr_ptr - rd_ptr;
  assign in_ready = (count != DEPTH[AW:0]);  // full stops the source
  assign out_valid = (count != '0);  // not empty
  assign out_data = mem[rd_ptr[AW-1:0]];
  // pointer update
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= rd_ptr + 1'b1;
    end
  end
  // storage write, no reset needed
  always_ff @(posedge core_clk) begin
    if (do_wr) mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule

// ---- logic/sfb_builder.sv ----
// status frame builder: modem status and extended transmit status frames
// Function
// - frame opens with start delimiter byte
// - length counts bytes between length and checksum
// - checksum is FF minus low sum
// - modem frame: type 8A, then status
// - status codes reset, watchdog, joined, left
// - status codes woke, sleep, voltage limit
// - 80 to FF mean stack error
// - hardware reset status sent after power up
// - transmit status frame type 8B on completion
// - frame id zero suppresses transmit status
// - offset four echoes frame id
// - offsets five, six hold FFFE
// - offset seven holds retry count
// - delivery codes 00, 01, 02, 21
// - delivery codes 25, 31, 32, 74
// - broadcast always reports success
// - offset nine holds discovery overhead
// - only request types 10, 11 answered

// frame layouts, one byte per fifo word, most significant byte first:
// modem status: start, length 0002, type, status code, checksum
// transmit status: start, length 0007, type, frame id, reserved high,
//   reserved low, retry count, delivery code, discovery code, checksum
// byte offsets of the modem status frame
//   0 start delimiter
//   1 length high
//   2 length low
//   3 frame type
//   4 status code
//   5 checksum
// byte offsets of the transmit status frame
//   0 start delimiter
//   1 length high
//   2 length low
//   3 frame type
//   4 frame id of the request
//   5 reserved high
//   6 reserved low
//   7 retry count
//   8 delivery code
//   9 discovery code
//   10 checksum
// checksum arithmetic:
//   the sum runs over offset three up to the byte before the checksum
//   only its low eight bits are kept, so the accumulator is eight bits
//   the checksum byte itself is also added into the running sum as it is pushed
//   the accumulator clears whenever the sender is idle
// input handshakes:
//   a request is taken on a rising edge with valid and ready high
//   ready falls after a take, except after a refused transmit request, and returns once the frame is in the fifo
//   a completed transmit request wins over a pending modem code
//   a modem code taken while a transmit frame starts waits in a holding register
// reset behaviour:
//   all handshakes and the link valid are low while reset is held
//   after release the hardware reset status frame is built first
//   input readies stay low until that frame is in the fifo
//   the fifo contents need no reset; only its pointers are cleared
// hazards and limits:
//   refused transmit requests are taken and leave no frame behind
//   unknown modem codes go out as the lowest stack error code
//   unknown delivery codes go out as internal resource error
//   discovery codes other than route discovery go out as none
//   a continuous stream of transmit completions can hold off modem codes
//   the fifo absorbs host stalls; the builder waits when it is full
//   the link outputs come from an output register fed by the fifo,
//   so the first byte appears two cycles after a transmit request is taken, three after a modem code
`timescale 1ns/100ps
module sfb_builder
  import sfb_pkg::*;
#(
  parameter int FIFO_DEPTH = sfb_pkg::SFB_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] modem_status,
  input wire logic modem_valid,
  output logic modem_ready,
  input wire sfb_pkg::sfb_txdone_t txdone,
  input wire logic txdone_valid,
  output logic txdone_ready,
  output logic [7:0] ser_data,
  output logic ser_last,
  output logic ser_valid,
  input wire logic ser_ready
);
  import sfb_pkg::*;

  // refuse a fifo too small to be a buffer
  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("sfb_builder: fifo depth below 2");
    end
  end

  // status code check, used for the modem_status input
  function automatic logic known_modem(input logic [7:0] c);
    case (c)
      SFB_MS_HW_RESET: known_modem = 1'b1;
      SFB_MS_WDOG: known_modem = 1'b1;
      SFB_MS_JOINED: known_modem = 1'b1;
      SFB_MS_LEFT: known_modem = 1'b1;
      SFB_MS_WOKE: known_modem = 1'b1;
      SFB_MS_SLEEP: known_modem = 1'b1;
      SFB_MS_VOLT: known_modem = 1'b1;
      default: known_modem = (c >= SFB_MS_STACK_MIN);
    endcase
  endfunction

  // delivery code check
  function automatic logic known_deliv(input logic [7:0] c);
    case (c)
      SFB_DS_OK: known_deliv = 1'b1;
      SFB_DS_MAC_ACK: known_deliv = 1'b1;
      SFB_DS_CCA: known_deliv = 1'b1;
      SFB_DS_NET_ACK: known_deliv = 1'b1;
      SFB_DS_NO_ROUTE: known_deliv = 1'b1;
      SFB_DS_INTERNAL: known_deliv = 1'b1;
      SFB_DS_NO_BUF: known_deliv = 1'b1;
      SFB_DS_TOO_BIG: known_deliv = 1'b1;
      default: known_deliv = 1'b0;  // unknown code
    endcase
  endfunction

  sfb_state_t state;  // frame sender state
  logic boot_pend;  // power-up frame still owed
  logic is_txst;  // current frame is a transmit status
  logic [3:0] ofs;  // byte offset in current frame
  logic [7:0] sum;  // running sum from offset three
  logic [7:0] f_b4;  // status byte or frame id
  logic [7:0] f_retry;  // retry count
  logic [7:0] f_deliv;  // delivery status
  logic [7:0] f_disc;  // discovery status
  logic mready;  // modem input ready
  logic tready;  // transmit done input ready
  // holding register for every taken modem code until the sender starts its frame
  logic mod_pend;  // a taken modem code still waits for its frame
  logic [7:0] mod_code;  // the waiting modem code, already screened
  // output register: the link sees flip-flops only
  logic out_full;  // output register holds a byte for the host
  logic [7:0] out_data;  // byte offered to the host
  logic out_last;  // byte offered is a checksum

  // fifo side wiring
  sfb_byte_t fifo_in;
  sfb_byte_t fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;  // fifo head holds a byte

  // request classification
  wire logic req_type_ok = (txdone.req_type == SFB_REQ_TX) ||
    (txdone.req_type == SFB_REQ_EXPL);
  wire logic req_fid_ok = (txdone.frame_id != SFB_FID_NONE);
  wire logic tx_accept = txdone_valid && tready;
  wire logic tx_emit = tx_accept && req_type_ok && req_fid_ok;
  // unknown modem codes are reported as a stack error
  wire logic [7:0] modem_code = known_modem(modem_status) ? modem_status :
    SFB_MS_STACK_MIN;
  // unknown delivery codes fall back to internal resource error
  wire logic [7:0] deliv_code = txdone.broadcast ? SFB_DS_OK :
    (known_deliv(txdone.delivery) ? txdone.delivery : SFB_DS_INTERNAL);
  wire logic [7:0] disc_code = (txdone.discovery == SFB_DISC_ROUTE) ?
    SFB_DISC_ROUTE : SFB_DISC_NONE;
  wire logic m_accept = modem_valid && mready;
  wire logic start_boot = (state == SFB_IDLE) && boot_pend;
  wire logic start_mod = (state == SFB_IDLE) && !boot_pend && mod_pend && !tx_emit;
  wire logic start_tx = tx_emit;

  // frame length and last offset
  wire logic [15:0] frame_len = is_txst ? SFB_LEN_TXST : SFB_LEN_MODEM;
  wire logic [3:0] last_ofs = is_txst ? SFB_LAST_TXST : SFB_LAST_MODEM;
  wire logic [7:0] frame_type = is_txst ? SFB_TYPE_TXST : SFB_TYPE_MODEM;

  // byte selection by offset
  logic [7:0] cur_byte;
  always_comb begin
    cur_byte = SFB_START;
    if (ofs == last_ofs) begin
      cur_byte = SFB_CKS_BASE - sum;
    end else begin
      case (ofs)
        SFB_OFS_LEN_HI: cur_byte = frame_len[15:8];
        SFB_OFS_LEN_LO: cur_byte = frame_len[7:0];
        SFB_OFS_TYPE: cur_byte = frame_type;
        SFB_OFS_B4: cur_byte = f_b4;
        SFB_OFS_RSV_HI: cur_byte = SFB_RESERVED[15:8];
        SFB_OFS_RSV_LO: cur_byte = SFB_RESERVED[7:0];
        SFB_OFS_RETRY: cur_byte = f_retry;
        SFB_OFS_DELIV: cur_byte = f_deliv;
        SFB_OFS_DISC: cur_byte = f_disc;
        default: cur_byte = SFB_START;
      endcase
    end
  end

  wire logic sending = (state == SFB_SEND);
  wire logic push = sending && fifo_in_ready;
  wire logic at_last = (ofs == last_ofs);
  assign fifo_in.data = cur_byte;
  assign fifo_in.last = at_last;

  // next-state logic for the sender
  sfb_state_t next_state;
  always_comb begin
    case (state)
      SFB_IDLE: next_state = (start_boot || start_mod || start_tx) ? SFB_SEND : SFB_IDLE;
      SFB_SEND: next_state = (push && at_last) ? SFB_IDLE : SFB_SEND;
      default: next_state = SFB_IDLE;
    endcase
  end

  // next input readiness: only in idle, boot frame first, transmit status wins
  wire logic next_idle = (next_state == SFB_IDLE);
  wire logic next_mready = next_idle && !(state == SFB_IDLE && boot_pend) &&
    !(txdone_valid && !start_tx);
  wire logic next_tready = next_idle && !(state == SFB_IDLE && boot_pend);

  // sender state and handshakes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= SFB_IDLE;
      boot_pend <= 1'b1;
      mready <= 1'b0;
      tready <= 1'b0;
    end else begin
      state <= next_state;
      if (start_boot) boot_pend <= 1'b0;
      mready <= next_mready && !start_tx && !start_boot && !m_accept && !mod_pend;
      tready <= next_tready && !start_tx && !start_boot && !start_mod;
    end
  end

  // offset counter and checksum accumulator
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ofs <= '0;
      sum <= '0;
    end else if (state == SFB_IDLE) begin
      ofs <= '0;
      sum <= '0;
    end else if (push) begin
      ofs <= at_last ? '0 : ofs + 1'b1;
      if (ofs >= SFB_OFS_TYPE) sum <= sum + cur_byte;
    end
  end

  // field capture at frame start
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      is_txst <= 1'b0;
      f_b4 <= '0;
      f_retry <= '0;
      f_deliv <= '0;
      f_disc <= '0;
    end else if (start_boot) begin
      is_txst <= 1'b0;
      f_b4 <= SFB_MS_HW_RESET;
    end else if (start_tx) begin
      is_txst <= 1'b1;
      f_b4 <= txdone.frame_id;
      f_retry <= txdone.retries;
      f_deliv <= deliv_code;
      f_disc <= disc_code;
    end else if (start_mod) begin
      is_txst <= 1'b0;
      f_b4 <= mod_code;
    end
  end

  // modem holding register: a taken code is never lost to a transmit frame
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mod_pend <= 1'b0;
      mod_code <= SFB_MS_HW_RESET;
    end else if (m_accept) begin
      // capture the screened code, the sender starts it when free
      mod_pend <= 1'b1;
      mod_code <= modem_code;
    end else if (start_mod) begin
      // the frame has started, the register is free again
      mod_pend <= 1'b0;
    end
  end

  // output register refills whenever it is empty or being taken
  wire logic out_take = !out_full || ser_ready;

  // output register between fifo head and link
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      out_full <= 1'b0;
      out_data <= '0;
      out_last <= 1'b0;
    end else if (out_take) begin
      // load the fifo head, or go empty when the fifo is empty
      out_full <= fifo_out_valid;
      out_data <= fifo_out.data;
      out_last <= fifo_out.last;
    end
  end

  assign modem_ready = mready;
  assign txdone_ready = tready;

  // output buffer between frame builder and serial link
  sfb_fifo #(
    .WIDTH($bits(sfb_byte_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_data(fifo_in),
    .in_valid(sending),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(out_take)
  );
  assign ser_data = out_data;
  assign ser_last = out_last;
  assign ser_valid = out_full;
endmodule

// ---- bench/sfb_builder_checker.sv ----
// concurrent checks on the serial frame stream of the status frame builder
`timescale 1ns/100ps
module sfb_builder_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] ser_data,
  input wire logic ser_last,
  input wire logic ser_valid,
  input wire logic ser_ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [3:0] ofs; // offset of the head byte in its frame
  logic [7:0] typ; // frame type seen at offset three
  logic [7:0] sum; // running sum from offset three
  // track offset, type and sum of taken bytes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ofs <= 4'h0;
      typ <= 8'h00;
      sum <= 8'h00;
    end else if (ser_valid && ser_ready) begin
      ofs <= ser_last ? 4'h0 : ofs + 4'h1;
      if (ofs == 4'h3) typ <= ser_data;
      sum <= (ofs < 4'h3 || ser_last) ? 8'h00 : sum + ser_data;
    end
  end
  // a byte offered but not taken
  sequence stall_s;
    ser_valid && !ser_ready;
  endsequence
  start_byte_a: assert property (ser_valid && ofs == 4'h0 |-> ser_data == 8'h7E)
    else $error("frame does not open with start byte");
  len_high_a: assert property (ser_valid && ofs == 4'h1 |-> ser_data == 8'h00)
    else $error("length high byte wrong");
  len_low_a: assert property (ser_valid && ofs == 4'h2 |-> ser_data inside {8'h02, 8'h07})
    else $error("length low byte wrong");
  frame_type_a: assert property (ser_valid && ofs == 4'h3 |-> ser_data inside {8'h8A, 8'h8B})
    else $error("frame type wrong");
  fid_nonzero_a: assert property (ser_valid && ofs == 4'h4 && typ == 8'h8B |-> ser_data != 8'h00)
    else $error("status frame sent for frame id zero");
  rsv_high_a: assert property (ser_valid && ofs == 4'h5 && typ == 8'h8B |-> ser_data == 8'hFF)
    else $error("reserved high byte wrong");
  rsv_low_a: assert property (ser_valid && ofs == 4'h6 && typ == 8'h8B |-> ser_data == 8'hFE)
    else $error("reserved low byte wrong");
  disc_code_a: assert property (ser_valid && ofs == 4'h9 |-> ser_data inside {8'h00, 8'h02})
    else $error("discovery code wrong");
  last_place_a: assert property (ser_valid && ser_last |-> ofs == (typ == 8'h8A ? 4'h5 : 4'hA))
    else $error("last byte at wrong offset");
  checksum_ok_a: assert property (ser_valid && ser_last |-> ser_data == 8'hFF - sum)
    else $error("checksum wrong");
  byte_hold_a: assert property (stall_s |=> ser_valid && $stable(ser_data) && $stable(ser_last))
    else $error("byte changed before taken");
endmodule
bind sfb_builder sfb_builder_checker chk_i (.core_clk(core_clk), .nrst(nrst),
  .ser_data(ser_data), .ser_last(ser_last), .ser_valid(ser_valid), .ser_ready(ser_ready));

// ---- bench/sfb_host_sink.sv ----
// host side model: takes serial bytes, may stall, checks length and checksum
`timescale 1ns/100ps
module sfb_host_sink (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] ser_data,
  input wire logic ser_last,
  input wire logic ser_valid,
  input wire logic stall,
  output logic ser_ready,
  output logic bad
);
  logic [3:0] cnt; // stall pacing counter
  logic [5:0] n; // byte offset in frame
  logic [15:0] len; // length assembled high byte first
  logic [7:0] sum; // sum from offset three
  // pace ready and judge each frame at its last byte
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      {cnt, n, len, sum, ser_ready, bad} <= '0;
    end else begin
      cnt <= cnt + 4'h1;
      ser_ready <= !stall || cnt == 4'hF;
      if (ser_valid && ser_ready) begin
        n <= ser_last ? 6'h00 : n + 6'h01;
        if (n == 6'h01) len[15:8] <= ser_data;
        if (n == 6'h02) len[7:0] <= ser_data;
        sum <= (n < 6'h03) ? 8'h00 : sum + ser_data;
        if (ser_last && (ser_data != 8'hFF - sum || 16'(n) != len + 16'h3)) bad <= 1'b1;
      end
    end
  end
endmodule

// ---- bench/test_status_frame_builder.sv ----
// testbench for the status frame builder
`timescale 1ns/100ps
module test_status_frame_builder;
  import sfb_pkg::*;
  logic core_clk = 0, nrst = 0, modem_valid = 0, txdone_valid = 0, stall = 0;
  logic [7:0] modem_status = 8'h00;
  sfb_txdone_t txdone = '0;
  logic modem_ready, txdone_ready, ser_last, ser_valid, ser_ready, bad;
  logic [7:0] ser_data;
  int mismatches = 0, checks_done = 0;
  logic [7:0] rx[$]; // bytes taken by the host
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (ser_valid && ser_ready) rx.push_back(ser_data);
  sfb_builder dut (.core_clk(core_clk), .nrst(nrst), .modem_status(modem_status),
    .modem_valid(modem_valid), .modem_ready(modem_ready), .txdone(txdone),
    .txdone_valid(txdone_valid), .txdone_ready(txdone_ready), .ser_data(ser_data),
    .ser_last(ser_last), .ser_valid(ser_valid), .ser_ready(ser_ready));
  sfb_host_sink host (.core_clk(core_clk), .nrst(nrst), .ser_data(ser_data),
    .ser_last(ser_last), .ser_valid(ser_valid), .stall(stall), .ser_ready(ser_ready), .bad(bad));
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // compare the next whole frame taken by the host
  task frame(input logic [7:0] p[$]);
    logic [7:0] f[$];
    logic [7:0] s;
    int w;
    s = 8'hFF;
    f = {8'h7E, 8'h00, 8'(p.size())};
    foreach (p[i]) begin
      f.push_back(p[i]);
      s = s - p[i];
    end
    f.push_back(s);
    foreach (f[i]) begin
      for (w = 0; w < 2000 && rx.size() == 0; w++) @(negedge core_clk);
      if (rx.size() == 0) begin
        mismatches++;
        report_and_stop();
      end
      chk("frame byte", rx.pop_front(), f[i]);
    end
  endtask
  // raise valid and hold it until the edge at which ready is seen high
  task req(input bit tx);
    int w;
    if (tx) txdone_valid <= 1'b1;
    else modem_valid <= 1'b1;
    for (w = 0; w < 2000; w++) begin
      @(posedge core_clk);
      if ((tx ? txdone_ready : modem_ready) === 1'b1) break;
    end
    txdone_valid <= 1'b0;
    modem_valid <= 1'b0;
    if (w == 2000) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task send_modem(input logic [7:0] c);
    @(posedge core_clk);
    modem_status <= c;
    req(1'b0);
  endtask
  task send_tx(input logic [7:0] rt, fid, rty, dl, ds, input logic bc);
    @(posedge core_clk);
    txdone <= '{rt, fid, rty, dl, ds, bc};
    req(1'b1);
  endtask
  task tx_case(input logic [7:0] rt, fid, rty, dl, ds, input logic bc);
    send_tx(rt, fid, rty, dl, ds, bc);
    frame({8'h8B, fid, 8'hFF, 8'hFE, rty, bc ? 8'h00 : dl, ds});
  endtask
  task t_modem;
    logic [7:0] c[8];
    c = '{8'h01, 8'h02, 8'h03, 8'h0B, 8'h0C, 8'h0D, 8'h85, 8'hFF};
    foreach (c[i]) begin
      send_modem(c[i]);
      frame({8'h8A, c[i]});
    end
  endtask
  task t_deliv;
    logic [7:0] d[8];
    d = '{8'h00, 8'h01, 8'h02, 8'h21, 8'h25, 8'h31, 8'h32, 8'h74};
    foreach (d[i]) tx_case(i % 2 ? 8'h11 : 8'h10, 8'(i + 1), 8'(i), d[i], i % 2 ? 8'h02 : 8'h00, 1'b0);
  endtask
  // refused requests leave no frame ahead of the next one
  task t_drop;
    send_tx(8'h20, 8'h05, 8'h00, 8'h00, 8'h00, 1'b0);
    send_tx(8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    send_modem(8'h02);
    frame({8'h8A, 8'h02});
    tx_case(8'h10, 8'h7E, 8'h03, 8'h21, 8'h02, 1'b1);
  endtask
  // unknown codes go out as the fallback codes
  task t_fallback;
    send_modem(8'h06);
    frame({8'h8A, 8'h80});
    send_tx(8'h10, 8'h22, 8'h01, 8'h03, 8'h05, 1'b0);
    frame({8'h8B, 8'h22, 8'hFF, 8'hFE, 8'h01, 8'h31, 8'h00});
  endtask
  // host stalls while frames pile up in the fifo
  task t_stall;
    @(posedge core_clk) stall <= 1'b1;
    for (int i = 0; i < 3; i++) send_tx(8'h11, 8'(8'h40 + i), 8'hFF, 8'h25, 8'h00, 1'b0);
    for (int i = 0; i < 3; i++) frame({8'h8B, 8'(8'h40 + i), 8'hFF, 8'hFE, 8'hFF, 8'h25, 8'h00});
    @(posedge core_clk) stall <= 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    frame({8'h8A, 8'h00});
    t_modem();
    t_deliv();
    t_drop();
    t_fallback();
    t_stall();
    chk("host frame check", {7'h00, bad}, 8'h00);
    report_and_stop();
  end
endmodule
